/* hdl/fepc_coding.sv */
/*
 * Digital coding path of a 10/100 twisted-pair transceiver: 100 Mb/s transmit and
 * receive coding, 10 Mb/s Manchester receive, system clock rate ticks, crossover
 * selection and speed negotiation with parallel detection.
 * Assumes lineClk is the clock recovered from the receive line transitions, and that
 * the analog front end slices the line into three-level codes and signals pair energy.
 */
`timescale 1ns/1ps
module fepc_coding #(
	parameter int XOVER_SLOT = fepc_pkg::XOVER_SLOT_CYC
) (
	// System clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Recovered receive line clock
	input wire logic lineClk,
	// MAC transmit side
	input wire fepc_pkg::fepc_mii_t miiTx,
	output logic miiTxTake,
	// MAC receive side
	output fepc_pkg::fepc_mii_t miiRx,
	output logic rx10Clk,
	// Line side, three-level codes and Manchester level
	output logic [1:0] txLevel,
	input wire logic [1:0] rxLevel,
	input wire logic m10Level,
	// Pair energy and crossover
	input wire logic energyPairA,
	input wire logic energyPairB,
	input wire logic [15:0] portCtl,
	input wire logic xoverStd,
	output logic mdix,
	// Clock rate select
	input wire logic [1:0] clkSel,
	output logic sysTick,
	// Negotiation
	input wire logic anEnable,
	input wire logic forceSpeed100,
	input wire fepc_pkg::fepc_abil_t advLocal,
	input wire fepc_pkg::fepc_abil_t partnerAbil,
	output fepc_pkg::fepc_abil_t advertise,
	output logic flpSend,
	output logic speed100,
	output logic linkUp
);
	import fepc_pkg::*;

	typedef enum logic [2:0] {TX_IDLE, TX_K, TX_DATA, TX_R, TX_ENDR} fepc_txph_t;
	typedef enum logic {AN_ABILITY, AN_LINKED} fepc_an_t;

	// Transmit path state
	fepc_txph_t txPh_q;
	logic [2:0] txCnt_q;
	logic [4:0] txSh_q;
	logic [SCR_LEN-1:0] txScr_q;
	logic txNrzi_q;
	logic [1:0] txStep_q;
	logic txLoad;
	logic [4:0] txGrp;
	logic txScrBit;

	// Group boundary every five bit times at 125 MHz
	assign txLoad = (txCnt_q == GRP_LAST);
	assign miiTxTake = txLoad && (txPh_q == TX_DATA) && miiTx.en;

	// Next code group: J K start, data, T R end, idle otherwise
	always_comb begin
		txGrp = CG_IDLE;
		unique case (txPh_q)
			TX_IDLE: txGrp = miiTx.en ? CG_J : CG_IDLE;
			TX_K: txGrp = CG_K;
			TX_DATA: txGrp = miiTx.en ? fepcEnc(miiTx.data) : CG_T;
			TX_R: txGrp = CG_R;
			TX_ENDR: txGrp = CG_IDLE;
		endcase
	end

	// Frame phase sequencer
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			txPh_q <= TX_IDLE;
		end else if (txLoad) begin
			unique case (txPh_q)
				TX_IDLE: txPh_q <= miiTx.en ? TX_K : TX_IDLE;
				TX_K: txPh_q <= TX_DATA;
				TX_DATA: txPh_q <= miiTx.en ? TX_DATA : TX_R;
				TX_R: txPh_q <= TX_ENDR;
				TX_ENDR: txPh_q <= TX_IDLE;
			endcase
		end
	end

	// Serialiser: group loaded, then shifted out most significant bit first
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			txCnt_q <= 3'h0;
			txSh_q <= CG_IDLE;
		end else begin
			txCnt_q <= txLoad ? 3'h0 : txCnt_q + 3'h1;
			txSh_q <= txLoad ? txGrp : {txSh_q[3:0], 1'b0};
		end
	end

	// Scrambler, maximal length 2047-bit sequence
	assign txScrBit = txSh_q[GRP_BITS-1] ^ txScr_q[SCR_TAP_A] ^ txScr_q[SCR_TAP_B];
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			txScr_q <= SCR_SEED;
		end else begin
			txScr_q <= {txScr_q[SCR_LEN-2:0], txScr_q[SCR_TAP_A] ^ txScr_q[SCR_TAP_B]};
		end
	end

	// NRZI toggles on a one; each toggle steps MLT3 through 0,+,0,-
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			txNrzi_q <= 1'b0;
			txStep_q <= 2'h0;
			txLevel <= MLT_ZERO;
		end else begin
			txNrzi_q <= txNrzi_q ^ txScrBit;
			if (txScrBit) begin
				txStep_q <= txStep_q + 2'h1;
				unique case (txStep_q + 2'h1)
					2'h1: txLevel <= MLT_POS;
					2'h3: txLevel <= MLT_NEG;
					default: txLevel <= MLT_ZERO;
				endcase
			end
		end
	end

	// Line domain reset release and level synchroniser
	logic [1:0] lnRst_q;
	logic [1:0] lvlS1_q;
	logic [1:0] lvlS2_q;
	logic [1:0] lvlPrev_q;
	always_ff @(posedge lineClk or negedge reset_n) begin
		if (!reset_n) begin
			lnRst_q <= 2'h0;
			lvlS1_q <= MLT_ZERO;
			lvlS2_q <= MLT_ZERO;
		end else begin
			lnRst_q <= {lnRst_q[0], 1'b1};
			lvlS1_q <= rxLevel;
			lvlS2_q <= lvlS1_q;
		end
	end

	// Receive line state
	logic rxNrzi_q;
	logic rxNrziPrev_q;
	logic [SCR_LEN-1:0] rxScr_q;
	logic rxLock_q;
	logic [6:0] rxIdleCnt_q;
	logic [9:0] rxWin_q;
	logic rxFrame_q;
	logic [2:0] rxCnt_q;
	fepc_mii_t rxWord_q;
	logic rxTog_q;
	logic rxNrz;
	logic rxKey;
	logic rxPlain;
	logic [4:0] rxDec;
	logic lnRst_n;

	assign lnRst_n = lnRst_q[1];
	assign rxNrz = rxNrzi_q ^ rxNrziPrev_q;
	assign rxKey = rxScr_q[SCR_TAP_A] ^ rxScr_q[SCR_TAP_B];
	assign rxPlain = rxNrz ^ rxKey;
	assign rxDec = fepcDec(rxWin_q[4:0]);

	// Any MLT3 level change marks an NRZI toggle
	always_ff @(posedge lineClk or negedge reset_n) begin
		if (!reset_n) begin
			lvlPrev_q <= MLT_ZERO;
			rxNrzi_q <= 1'b0;
			rxNrziPrev_q <= 1'b0;
		end else begin
			lvlPrev_q <= lvlS2_q;
			rxNrzi_q <= rxNrzi_q ^ (lvlS2_q != lvlPrev_q);
			rxNrziPrev_q <= rxNrzi_q;
		end
	end

	// Self-synchronising descrambler: unlocked, idle ones reveal the key stream
	// Lock is held until a line domain reset, since unaligned idle-to-J windows look invalid
	always_ff @(posedge lineClk or negedge reset_n) begin
		if (!reset_n) begin
			rxScr_q <= SCR_SEED;
			rxLock_q <= 1'b0;
			rxIdleCnt_q <= 7'h00;
		end else if (!lnRst_n) begin
			rxLock_q <= 1'b0;
			rxIdleCnt_q <= 7'h00;
		end else begin
			rxScr_q <= {rxScr_q[SCR_LEN-2:0], rxLock_q ? rxKey : ~rxNrz};
			if (!rxPlain) begin
				rxIdleCnt_q <= 7'h00;
			end else if (rxIdleCnt_q == RX_LOCK_BITS) begin
				rxLock_q <= 1'b1;
			end else begin
				rxIdleCnt_q <= rxIdleCnt_q + 7'h01;
			end
		end
	end

	// Group alignment on J K, then five-bit groups decoded into nibbles
	always_ff @(posedge lineClk or negedge reset_n) begin
		if (!reset_n) begin
			rxWin_q <= 10'h3FF;
			rxFrame_q <= 1'b0;
			rxCnt_q <= 3'h0;
			rxWord_q <= '0;
			rxTog_q <= 1'b0;
		end else begin
			rxWin_q <= {rxWin_q[8:0], rxPlain};
			rxCnt_q <= (rxCnt_q == GRP_LAST) ? 3'h0 : rxCnt_q + 3'h1;
			if (!rxFrame_q) begin
				if (rxLock_q && rxWin_q == {CG_J, CG_K}) begin
					rxFrame_q <= 1'b1;
					rxCnt_q <= 3'h0; // First data bit enters on this edge
				end
			end else if (rxCnt_q == GRP_LAST) begin
				rxTog_q <= ~rxTog_q;
				if (rxWin_q[4:0] == CG_T || rxWin_q[4:0] == CG_IDLE) begin
					rxFrame_q <= 1'b0;
					rxWord_q <= '0;
				end else begin
					rxWord_q <= '{en: 1'b1, err: ~rxDec[4], data: rxDec[3:0]};
				end
			end
		end
	end

	// Word crossing by toggle and lock level crossing into the system clock
	logic [2:0] xTog_q;
	logic [1:0] xLock_q;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			xTog_q <= 3'h0;
			xLock_q <= 2'h0;
		end else begin
			xTog_q <= {xTog_q[1:0], rxTog_q};
			xLock_q <= {xLock_q[0], rxLock_q};
		end
	end

	// Shared two-stage synchroniser for pins sampled on the system clock
	logic [4:0] pinS1_q;
	logic [4:0] pinS2_q;
	fepc_abil_t ptnrS1_q;
	fepc_abil_t ptnr_q;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinS1_q <= 5'h00;
			pinS2_q <= 5'h00;
			ptnrS1_q <= '0;
			ptnr_q <= '0;
		end else begin
			pinS1_q <= {m10Level, energyPairA, energyPairB, 2'h0};
			pinS2_q <= pinS1_q;
			ptnrS1_q <= partnerAbil;
			ptnr_q <= ptnrS1_q;
		end
	end

	// 10 Mb/s Manchester recovery: mid-bit edges give data, divider gives clock
	logic m10Prev_q;
	logic [4:0] m10Hold_q;
	logic [4:0] m10Div_q;
	logic [4:0] m10Loss_q;
	logic m10Car_q;
	logic [3:0] m10Sh_q;
	logic [1:0] m10Cnt_q;
	logic m10Nib_q;
	logic m10Edge;
	assign m10Edge = (pinS2_q[4] != m10Prev_q) && (m10Hold_q == 5'h00);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			m10Prev_q <= 1'b0;
			m10Hold_q <= 5'h00;
			m10Div_q <= 5'h00;
			m10Loss_q <= 5'h00;
			m10Car_q <= 1'b0;
			m10Sh_q <= 4'h0;
			m10Cnt_q <= 2'h0;
			m10Nib_q <= 1'b0;
			rx10Clk <= 1'b0;
		end else begin
			m10Prev_q <= pinS2_q[4];
			m10Nib_q <= 1'b0;
			// Free-running bit clock, re-phased on data, kept alive when idle
			m10Div_q <= (m10Edge || m10Div_q == 5'(M10_BIT_CYC - 1)) ? 5'h00 : m10Div_q + 5'h01;
			rx10Clk <= (m10Div_q < 5'(M10_BIT_CYC / 2));
			if (m10Edge) begin
				m10Hold_q <= 5'(M10_HOLD_CYC);
				m10Loss_q <= 5'h00;
				m10Car_q <= 1'b1;
				m10Sh_q <= {pinS2_q[4], m10Sh_q[3:1]};
				m10Cnt_q <= m10Cnt_q + 2'h1;
				m10Nib_q <= (m10Cnt_q == 2'h3);
			end else begin
				m10Hold_q <= (m10Hold_q == 5'h00) ? 5'h00 : m10Hold_q - 5'h01;
				if (m10Loss_q == 5'(M10_LOSS_CYC)) begin
					m10Car_q <= 1'b0;
					m10Cnt_q <= 2'h0;
				end else begin
					m10Loss_q <= m10Loss_q + 5'h01;
				end
			end
		end
	end

	// MAC receive nibble: 100M word on toggle edge, 10M nibble when four bits are in
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			miiRx <= '0;
		end else if (speed100) begin
			if (xTog_q[2] != xTog_q[1]) begin
				miiRx <= rxWord_q;
			end
		end else if (m10Nib_q) begin
			miiRx <= '{en: 1'b1, err: 1'b0, data: {pinS2_q[4], m10Sh_q[3:1]}};
		end else if (!m10Car_q) begin
			miiRx <= '0;
		end
	end

	// System clock rate ticks from the selected divider
	logic [2:0] divCnt_q;
	logic [2:0] divSel;
	always_comb begin
		unique case (clkSel)
			2'h0: divSel = DIV_125;
			2'h1: divSel = DIV_62;
			2'h2: divSel = DIV_41;
			2'h3: divSel = DIV_25;
		endcase
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			divCnt_q <= 3'h0;
			sysTick <= 1'b0;
		end else begin
			divCnt_q <= (divCnt_q >= divSel - 3'h1) ? 3'h0 : divCnt_q + 3'h1;
			sysTick <= (divCnt_q == 3'h0);
		end
	end

	// Crossover: hold while the receive pair has energy, else try the other wiring
	logic [31:0] xoTmr_q;
	logic [3:0] xoRand_q;
	logic xoRxEnergy;
	assign xoRxEnergy = mdix ? pinS2_q[3] : pinS2_q[2];
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			xoTmr_q <= 32'h0;
			xoRand_q <= 4'h9;
			mdix <= 1'b0;
		end else begin
			xoRand_q <= {xoRand_q[2:0], xoRand_q[3] ^ xoRand_q[2]};
			if (portCtl[PCTL_XOVER_OFF]) begin
				mdix <= portCtl[PCTL_MANUAL_MDIX];
				xoTmr_q <= 32'h0;
			end else if (xoRxEnergy) begin
				xoTmr_q <= 32'h0;
			end else if (xoTmr_q == 32'(XOVER_SLOT - 1)) begin
				xoTmr_q <= 32'h0;
				// Vendor style alternates; standard picks at random
				mdix <= xoverStd ? (mdix ^ xoRand_q[0]) : ~mdix;
			end else begin
				xoTmr_q <= xoTmr_q + 32'h1;
			end
		end
	end

	// Negotiation with parallel detection of a fixed line signal
	fepc_an_t anSt_q;
	logic anSig;
	assign anSig = ptnr_q.valid || xLock_q[1] || m10Car_q;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			anSt_q <= AN_ABILITY;
			speed100 <= 1'b0;
			linkUp <= 1'b0;
			flpSend <= 1'b0;
			advertise <= '0;
		end else begin
			advertise <= '{valid: anEnable, can100: advLocal.can100, can10: advLocal.can10};
			if (!anEnable) begin
				anSt_q <= AN_LINKED;
				flpSend <= 1'b0;
				speed100 <= forceSpeed100;
				linkUp <= forceSpeed100 ? xLock_q[1] : m10Car_q;
			end else begin
				unique case (anSt_q)
					AN_ABILITY: begin
						flpSend <= 1'b1;
						linkUp <= 1'b0;
						if (ptnr_q.valid) begin
							anSt_q <= AN_LINKED;
							speed100 <= advLocal.can100 && ptnr_q.can100;
						end else if (xLock_q[1]) begin
							anSt_q <= AN_LINKED;
							speed100 <= 1'b1;
						end else if (m10Car_q) begin
							anSt_q <= AN_LINKED;
							speed100 <= 1'b0;
						end
					end
					AN_LINKED: begin
						flpSend <= 1'b0;
						linkUp <= anSig;
						if (!anSig) begin
							anSt_q <= AN_ABILITY;
						end
					end
				endcase
			end
		end
	end
endmodule

/* hdl/fepc_pkg.sv */
/*
 * Shared constants, carriers and code tables of the Fast Ethernet coding path.
 * Assumes a 125 MHz system clock and a receive line clock recovered by the analog front end.
 */
package fepc_pkg;
	// System clock rate and derived timing
	localparam int CLK_MHZ = 125;
	localparam int M10_BIT_NS = 100;
	localparam int M10_BIT_CYC = (M10_BIT_NS * CLK_MHZ) / 1000;
	localparam int M10_HOLD_CYC = (M10_BIT_CYC * 3) / 4;
	localparam int M10_LOSS_CYC = 2 * M10_BIT_CYC;
	localparam int XOVER_SLOT_US = 100;
	localparam int XOVER_SLOT_CYC = XOVER_SLOT_US * CLK_MHZ;
	// Code group length and receive lock length
	localparam int GRP_BITS = 5;
	localparam logic [2:0] GRP_LAST = 3'h4;
	localparam logic [6:0] RX_LOCK_BITS = 7'h3C;
	// Scrambler polynomial x^11 + x^9 + 1
	localparam int SCR_LEN = 11;
	localparam int SCR_TAP_A = 10;
	localparam int SCR_TAP_B = 8;
	localparam logic [10:0] SCR_SEED = 11'h7FF;
	// Control code groups
	localparam logic [4:0] CG_IDLE = 5'h1F;
	localparam logic [4:0] CG_J = 5'h18;
	localparam logic [4:0] CG_K = 5'h11;
	localparam logic [4:0] CG_T = 5'h0D;
	localparam logic [4:0] CG_R = 5'h07;
	// Three-level line codes
	localparam logic [1:0] MLT_ZERO = 2'h0;
	localparam logic [1:0] MLT_POS = 2'h1;
	localparam logic [1:0] MLT_NEG = 2'h3;
	// Port control bits and system clock dividers
	localparam int PCTL_XOVER_OFF = 10;
	localparam int PCTL_MANUAL_MDIX = 9;
	localparam logic [2:0] DIV_125 = 3'h1;
	localparam logic [2:0] DIV_62 = 3'h2;
	localparam logic [2:0] DIV_41 = 3'h3;
	localparam logic [2:0] DIV_25 = 3'h5;

	// One media-independent nibble with its qualifiers
	typedef struct packed {
		logic en;
		logic err;
		logic [3:0] data;
	} fepc_mii_t;

	// Abilities exchanged during negotiation
	typedef struct packed {
		logic valid;
		logic can100;
		logic can10;
	} fepc_abil_t;

	// Nibble to code group
	function automatic logic [4:0] fepcEnc(input logic [3:0] n);
		logic [4:0] c;
		c = CG_IDLE;
		unique case (n)
			4'h0: c = 5'h1E;
			4'h1: c = 5'h09;
			4'h2: c = 5'h14;
			4'h3: c = 5'h15;
			4'h4: c = 5'h0A;
			4'h5: c = 5'h0B;
			4'h6: c = 5'h0E;
			4'h7: c = 5'h0F;
			4'h8: c = 5'h12;
			4'h9: c = 5'h13;
			4'hA: c = 5'h16;
			4'hB: c = 5'h17;
			4'hC: c = 5'h1A;
			4'hD: c = 5'h1B;
			4'hE: c = 5'h1C;
			4'hF: c = 5'h1D;
		endcase
		return c;
	endfunction

	// Code group to {valid, nibble}
	function automatic logic [4:0] fepcDec(input logic [4:0] c);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < 16; i++) begin
			if (fepcEnc(4'(i)) == c) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction
endpackage

/* sim/fepc_coding_props.sv */
/*
 * Checker of the coding path: transmit pacing, line levels, crossover, rate ticks
 * and negotiation outputs.
 * Assumes it is bound to fepc_coding and sees only its ports.
 */
`timescale 1ns/1ps
module fepc_coding_props (
	// Clock and reset
	input logic ref_clk,
	input logic reset_n,
	// Transmit and receive clock
	input logic miiTxTake,
	input logic [1:0] txLevel,
	input logic rx10Clk,
	// Crossover
	input logic [15:0] portCtl,
	input logic energyPairB,
	input logic mdix,
	// Rate select
	input logic [1:0] clkSel,
	input logic sysTick,
	// Negotiation
	input logic anEnable,
	input logic forceSpeed100,
	input fepc_pkg::fepc_abil_t advLocal,
	input fepc_pkg::fepc_abil_t advertise,
	input logic flpSend,
	input logic speed100
);
	import fepc_pkg::*;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	// A nibble is taken once per five-bit group
	chk_take_spacing: assert property (miiTxTake |=> !miiTxTake [*4])
		else $error("transmit take pulses closer than one group");
	// Three-level output only steps through zero
	chk_mlt_steps: assert property ($changed(txLevel) |-> txLevel != 2'h2 &&
		(txLevel == MLT_ZERO || $past(txLevel) == MLT_ZERO))
		else $error("line level jumped between plus and minus");
	chk_manual_pair: assert property (portCtl[10] |=> mdix == $past(portCtl[9]))
		else $error("manual pair select not followed");
	chk_pair_hold: assert property ((!portCtl[10] && !mdix && energyPairB) [*4] |=> !mdix)
		else $error("pair changed while receive pair had energy");
	chk_tick_full: assert property ((clkSel == 2'h0) [*2] |-> sysTick)
		else $error("full rate tick missing");
	chk_tick_gap: assert property (sysTick && clkSel == 2'h3 |=>
		(!sysTick || clkSel != 2'h3) [*4])
		else $error("slowest rate ticks too close");
	chk_tick_due: assert property ((clkSel == 2'h2) [*6] |->
		sysTick || $past(sysTick) || $past(sysTick, 2))
		else $error("third rate tick missing");
	chk_adv_copy: assert property (1'h1 |=> advertise ==
		{$past(anEnable), $past(advLocal.can100), $past(advLocal.can10)})
		else $error("advertised abilities differ from local ones");
	chk_adv_quiet: assert property (!anEnable [*2] |-> !flpSend)
		else $error("advertising while negotiation disabled");
	chk_forced_speed: assert property ((!anEnable && $stable(forceSpeed100)) [*3] |->
		speed100 == forceSpeed100)
		else $error("forced speed not applied");
	chk_rx10_runs: assert property (1'h1 |-> ##[1:7] $changed(rx10Clk))
		else $error("ten megabit receive clock stopped");

	// Main scenarios
	cov_take: cover property (miiTxTake ##5 miiTxTake);
	cov_auto_pair: cover property (!portCtl[10] && $rose(mdix));
	cov_speed: cover property (anEnable && $rose(speed100));
	cov_adv: cover property ($rose(flpSend));
endmodule

bind fepc_coding fepc_coding_props chk (
	.ref_clk, .reset_n, .miiTxTake, .txLevel, .rx10Clk, .portCtl, .energyPairB, .mdix,
	.clkSel, .sysTick, .anEnable, .forceSpeed100, .advLocal, .advertise, .flpSend, .speed100
);

/* sim/fepc_link_partner.sv */
/*
 * Remote link partner: sends scrambled code groups as three-level line codes.
 * Assumes the bench pushes code groups into grpQ; idle is sent when it is empty.
 */
`timescale 1ns/1ps
module fepc_link_partner (
	// Line clock and reset
	input logic lineClk,
	input logic reset_n,
	// Line silent when high
	input logic quiet,
	// Sliced line code toward the device
	output logic [1:0] rxLevel
);
	import fepc_pkg::*;
	logic [4:0] grpQ[$];
	logic [10:0] scr;
	logic [4:0] grp;
	logic [2:0] bitN;
	logic [1:0] step;
	logic key;

	// Scramble each group bit, MSB first, and step the three-level code on ones
	always @(posedge lineClk or negedge reset_n) begin
		if (!reset_n) begin
			scr <= SCR_SEED;
			bitN <= 3'h0;
			step = 2'h0;
			rxLevel <= MLT_ZERO;
		end else if (quiet) begin
			rxLevel <= MLT_ZERO;
		end else begin
			if (bitN == 3'h0) grp = (grpQ.size() != 0) ? grpQ.pop_front() : CG_IDLE;
			key = scr[SCR_TAP_A] ^ scr[SCR_TAP_B];
			scr <= {scr[9:0], key};
			if (grp[3'h4 - bitN] ^ key) step = step + 2'h1;
			rxLevel <= step[0] ? (step[1] ? MLT_NEG : MLT_POS) : MLT_ZERO;
			bitN <= (bitN == 3'h4) ? 3'h0 : bitN + 3'h1;
		end
	end
endmodule

/* sim/fepc_coding_tb.sv */
/*
 * Self-checking bench of the coding path with a line partner model.
 * Assumes fepc_pkg and the partner model are compiled first.
 */
`timescale 1ns/1ps
module fepc_coding_tb;
	import fepc_pkg::*;
	localparam int SLOT = 50;
	localparam int RATE_DIV[4] = '{1, 2, 3, 5};
	localparam logic [4:0] CODE[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
		5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	logic ref_clk, lineClk, reset_n, miiTxTake, rx10Clk, m10Level, energyPairA, energyPairB;
	logic xoverStd, mdix, sysTick, anEnable, forceSpeed100, flpSend, speed100, linkUp;
	logic lineQuiet, inFrame, txBit, key;
	logic [1:0] txLevel, rxLevel, clkSel, prevLvl;
	logic [15:0] portCtl;
	logic [10:0] dsc;
	logic [9:0] win;
	logic [31:0] seed;
	logic [3:0] txSent[$], txSeen[$];
	fepc_mii_t miiTx, miiRx;
	fepc_abil_t advLocal, partnerAbil, advertise;
	int nErrors, numChecks, cyc, lockCnt, grpCnt;

	fepc_coding #(.XOVER_SLOT(SLOT)) dut (.ref_clk, .reset_n, .lineClk, .miiTx, .miiTxTake,
		.miiRx, .rx10Clk, .txLevel, .rxLevel, .m10Level, .energyPairA, .energyPairB,
		.portCtl, .xoverStd, .mdix, .clkSel, .sysTick, .anEnable, .forceSpeed100,
		.advLocal, .partnerAbil, .advertise, .flpSend, .speed100, .linkUp);
	fepc_link_partner lp (.lineClk, .reset_n, .quiet(lineQuiet), .rxLevel);

	// System clock and a free line clock of unrelated phase
	initial begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		lineClk = 1'h0;
		#37;
		forever #80 lineClk = ~lineClk;
	end

	// Cycle ceiling against hangs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			nErrors++;
			$display("MISMATCH run length expected below 40000 seen %0d", cyc);
			conclude();
		end
	end

	// Descramble the transmit line and collect nibbles between J K and T
	always @(negedge ref_clk) begin
		txBit = (txLevel != prevLvl);
		prevLvl = txLevel;
		key = (lockCnt < 40) ? ~txBit : dsc[SCR_TAP_A] ^ dsc[SCR_TAP_B];
		dsc = {dsc[9:0], key};
		win = {win[8:0], txBit ^ key};
		lockCnt = reset_n ? lockCnt + 1 : 0;
		if (!reset_n) inFrame = 1'h0;
		else if (!inFrame && win == {CG_J, CG_K}) begin
			inFrame = 1'h1;
			grpCnt = 0;
		end else if (inFrame && ++grpCnt == 5) begin
			grpCnt = 0;
			if (win[4:0] == CG_T) inFrame = 1'h0;
			else for (int i = 0; i < 16; i++) if (CODE[i] == win[4:0]) txSeen.push_back(4'(i));
		end
	end

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		numChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rst();
		reset_n = 1'h0;
		repeat (20) @(negedge ref_clk);
		check("reset outputs", 8'h00, {miiRx, txLevel});
		check("reset flags", 8'h00, {4'h0, mdix, speed100, linkUp, flpSend});
		reset_n = 1'h1;
		repeat (4) @(negedge ref_clk);
	endtask

	task automatic rates();
		int cnt;
		for (int s = 0; s < 4; s++) begin
			clkSel = 2'(s);
			repeat (10) @(negedge ref_clk);
			cnt = 0;
			repeat (60) begin
				@(negedge ref_clk);
				cnt += sysTick;
			end
			check("tick count", 8'(60 / RATE_DIV[s]), 8'(cnt));
		end
	endtask

	task automatic sendTx(input int n);
		int w;
		txSent.delete();
		txSeen.delete();
		for (int i = 0; i < n; i++) begin
			txSent.push_back(4'(rnd()));
			miiTx = {2'h2, txSent[i]};
			w = 0;
			do begin
				@(negedge ref_clk);
				w++;
			end while (miiTxTake !== 1'h1 && w < 400);
			if (i > 0) check("take spacing", 8'h04, 8'(w));
			@(negedge ref_clk);
		end
		miiTx = '0;
		repeat (60) @(negedge ref_clk);
		check("tx count", 8'(n), 8'(txSeen.size()));
		foreach (txSent[i]) check("tx nibble", 8'(txSent[i]), 8'(txSeen[i]));
	endtask

	task automatic sendRx(input int n, input int bad);
		logic [3:0] nib[$];
		int w;
		lp.grpQ.push_back(CG_J);
		lp.grpQ.push_back(CG_K);
		for (int i = 0; i < n; i++) begin
			nib.push_back(4'(rnd()));
			lp.grpQ.push_back(i == bad ? 5'h00 : CODE[nib[i]]);
		end
		lp.grpQ.push_back(CG_T);
		lp.grpQ.push_back(CG_R);
		w = 0;
		while (miiRx.en !== 1'h1 && w < 2000) begin
			@(negedge ref_clk);
			w++;
		end
		repeat (50) @(negedge ref_clk);
		for (int i = 0; i < n; i++) begin
			if (i == bad) check("rx code error", 8'h01, 8'(miiRx.err));
			else check("rx nibble", {4'h2, nib[i]}, 8'(miiRx));
			repeat (100) @(negedge ref_clk);
		end
		check("rx frame end", 8'h00, 8'(miiRx));
	endtask

	task automatic crossover(input logic std);
		int w;
		rst();
		xoverStd = std;
		portCtl = 16'h0000;
		w = 0;
		while (mdix !== 1'h1 && w < 200) begin
			@(negedge ref_clk);
			w++;
		end
		if (!std) check("vendor toggle", 8'h01, 8'(w <= SLOT + 20));
		energyPairA = !std;
		energyPairB = std;
		repeat (20 * SLOT) @(negedge ref_clk);
		check("pair match", 8'(!std), 8'(mdix));
		energyPairA = 1'h0;
		energyPairB = 1'h0;
		repeat (4) begin
			portCtl = 16'(rnd()) | 16'h0400;
			repeat (3) @(negedge ref_clk);
			check("manual pair", 8'(portCtl[9]), 8'(mdix));
		end
		$display("test crossover %0d done", std);
	endtask

	task automatic negotiate(input logic [2:0] loc, part, input logic lineOn, exp100);
		int w;
		anEnable = 1'h1;
		advLocal = loc;
		partnerAbil = '0;
		lineQuiet = 1'h1;
		rst();
		repeat (8) @(negedge ref_clk);
		check("advertising", 8'h01, 8'(flpSend));
		partnerAbil = part;
		lineQuiet = !lineOn;
		w = 0;
		while (linkUp !== 1'h1 && w < 5000) begin
			@(negedge ref_clk);
			if (!lineOn && w % 6 == 0) m10Level = ~m10Level;
			w++;
		end
		check("link up", 8'h01, 8'(linkUp));
		check("speed", 8'(exp100), 8'(speed100));
		$display("test negotiate %h %h done", loc, part);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		seed = 32'hFB3F4014;
		{miiTx, m10Level, energyPairA, energyPairB, portCtl, xoverStd, clkSel} = '0;
		{anEnable, partnerAbil, lineQuiet, reset_n} = '0;
		forceSpeed100 = 1'h1;
		advLocal = 3'h7;
		rst();
		rates();
		$display("test rates done");
		repeat (2100) @(negedge ref_clk);
		sendTx(12);
		sendTx(1);
		$display("test transmit done");
		sendRx(8, -1);
		sendRx(6, 2);
		$display("test receive done");
		crossover(1'h0);
		crossover(1'h1);
		negotiate(3'h7, 3'h7, 1'h1, 1'h1);
		negotiate(3'h7, 3'h5, 1'h1, 1'h0);
		negotiate(3'h5, 3'h7, 1'h1, 1'h0);
		negotiate(3'h7, 3'h0, 1'h1, 1'h1);
		negotiate(3'h7, 3'h0, 1'h0, 1'h0);
		conclude();
	end
endmodule
